// File: sefe_pkg.sv
// What this block does
// (R01) Serial modes (0,0) and (1,1) only
// (R02) Array of 256 bytes, 16-byte pages
// (R03) Write one byte or partial page
// (R04) Self-timed program cycle, at most 5 ms
// (R05) Protect none, quarter, half or all
// (R06) Reset ignores instructions, then enters standby
// (R07) Standby at frame end unless programming
// (R08) First byte after select is the opcode
// (R09) Master sends only defined opcodes
// (R10) All bytes shifted MSB first
// (R11) Master starts frame by lowering select
// (R12) Select rise ends frame or starts programming
// (R13) Serial output floats in standby
// (R14) Input sampled on rising serial clock
// (R15) Output changes on falling serial clock
// (R16) Hardware protect: write-protect low and enable set
// (R17) Hardware protect freezes protection bits
// (R18) Suspend freezes frame, resumes same bit
// (R19) Master moves suspend only with clock low
// (R20) Suspend held high has no effect
// (R21) While busy, only status read accepted
// (R22) Disable, status or array write clears enable
// (R23) Protect codes map to C0h, 80h, 00h bases
// (R24) Sequential read wraps last to zero
// (R25) Output floats while suspended
// (R26) Incomplete write discarded, bit counter cleared
package sefe_pkg;

  localparam int unsigned SYS_CLK_MHZ = 125;
  localparam int unsigned PROG_TIME_US = 5000;
  // Longest time: an exact whole number of cycles
  localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_US * SYS_CLK_MHZ;
  localparam int PROG_CNT_W = 20;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int ARRAY_BYTES = 256;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_W = 4;

  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] BYTE_OPCODE = 2'h0;
  localparam logic [1:0] BYTE_ADDR = 2'h1;
  localparam logic [1:0] BYTE_DATA = 2'h2;
  localparam logic [1:0] BYTE_SAT = 2'h3;

  localparam logic [7:0] OPCODE_MASK = 8'hf7;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;

  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WEN_BIT = 1;
  localparam int ST_BP_LO_BIT = 2;
  localparam int ST_BP_HI_BIT = 3;
  localparam int ST_PROTECT_ENABLE_BIT_BIT = 7;
  localparam logic [7:0] STATUS_BUSY_VAL = 8'hff;

  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [7:0] PROT_QUARTER_BASE = 8'hc0;
  localparam logic [7:0] PROT_HALF_BASE = 8'h80;

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_WREN = 3'b001,
    CMD_WRITE_DISABLE_CMD = 3'b010,
    CMD_STATUS_READ_CMD = 3'b011,
    CMD_STATUS_WRITE_CMD = 3'b100,
    CMD_READ = 3'b101,
    CMD_WRITE = 3'b110
  } sefe_cmd_t;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_PROGRAM = 2'b10
  } sefe_state_t;

  // Bit 3 of the opcode is a don't-care
  function automatic sefe_cmd_t sefe_decode(input logic [7:0] op);
    logic [7:0] m;
    m = op & OPCODE_MASK;
    if (m == OP_WRITE_ENABLE) return CMD_WREN;
    if (m == OP_WRITE_DISABLE) return CMD_WRITE_DISABLE_CMD;
    if (m == OP_STATUS_READ) return CMD_STATUS_READ_CMD;
    if (m == OP_STATUS_WRITE) return CMD_STATUS_WRITE_CMD;
    if (m == OP_READ) return CMD_READ;
    if (m == OP_WRITE) return CMD_WRITE;
    return CMD_NONE;
  endfunction : sefe_decode

  function automatic logic sefe_protected(input logic [1:0] bp, input logic [7:0] a);
    logic p;
    p = 1'b1;
    if (bp == BP_NONE) p = 1'b0;
    else if (bp == BP_QUARTER) p = (a >= PROT_QUARTER_BASE);
    else if (bp == BP_HALF) p = (a >= PROT_HALF_BASE);
    return p;
  endfunction : sefe_protected

endpackage : sefe_pkg

// File: sefe_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser, first stage read only by the second
module sefe_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // Destination clock
  input wire logic en, // Clock enable
  input wire logic [WIDTH-1:0] d, // Asynchronous input
  output logic [WIDTH-1:0] q // Synchronised output
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (en) begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : sefe_sync

// File: sefe_prog_timer.sv
`timescale 1ns/1ps
module sefe_prog_timer
  import sefe_pkg::*;
#(
  parameter int unsigned CYCLES = PROG_CYCLES_DEF
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic clk_en, // Clock enable
  input wire logic start, // Pulse: begin a program cycle
  output logic busy, // Program cycle running
  output logic done // Pulse: cycle finished
);

  localparam logic [PROG_CNT_W-1:0] LAST = PROG_CNT_W'(CYCLES - 1);

  logic [PROG_CNT_W-1:0] cnt;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= '0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        cnt <= '0;
      end else if (busy && cnt == LAST) begin // see (R04)
        busy <= 1'b0;
        done <= 1'b1;
      end else if (busy) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule : sefe_prog_timer

// File: sefe_top.sv
`timescale 1ns/1ps
module sefe_top
  import sefe_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
  input wire logic sys_clk, // System clock, 125 MHz
  input wire logic rst_n, // Power-on reset, synchronous, active low
  input wire logic clk_en, // Freezes system-side state when low
  input wire logic spi_sck, // Serial clock from master
  input wire logic spi_cs_n, // Chip select, active low
  input wire logic spi_si, // Serial data in
  input wire logic spi_hold_n, // Suspend, active low
  input wire logic wp_n, // Write protect, active low
  output logic spi_so, // Serial data out
  output logic spi_so_en_n, // Serial out enable, low drives
  output logic busy, // Program cycle running
  output logic standby, // Device in standby
  output logic write_enable, // Write enable latch
  output logic block_protect_lo, // Block protect low bit
  output logic block_protect_hi, // Block protect high bit
  output logic protect_enable_bit, // Protect enable bit
  output logic hw_protect // Hardware protection active
);

  // Storage, written only from the system side
  logic [DATA_W-1:0] mem [ARRAY_BYTES]; // see (R02)

  // ---------------- Link side (serial clock) ----------------
  logic [2:0] bit_cnt;
  logic [1:0] byte_cnt;
  sefe_cmd_t cmd;
  logic [PAGE_BYTES-1:0] wr_mask;
  logic [6:0] rx_sh;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] sr_data;
  logic [DATA_W-1:0] page_buf [PAGE_BYTES];
  logic [6:0] tx_sh;
  logic tx_on;
  logic [DATA_W-1:0] link_status;

  // ---------------- System side ----------------
  logic cs_s;
  logic hold_s;
  logic wp_s;
  logic tx_s;
  logic ack;
  logic ready;
  logic [DATA_W-1:0] status_reg;
  sefe_state_t state;
  sefe_state_t next_state;
  logic prog_done;

  // Link state is cleared only once the system side has read the frame
  wire link_clr = spi_cs_n & ack; // see (R26)

  wire [DATA_W-1:0] rx_byte = {rx_sh, spi_si}; // see (R10)
  wire byte_done = (bit_cnt == BIT_LAST);
  wire sefe_cmd_t dec_cmd = sefe_decode(rx_byte); // see (R08)
  wire link_busy = link_status[ST_BUSY_BIT];
  wire sefe_cmd_t next_cmd = (link_busy && dec_cmd != CMD_STATUS_READ_CMD) ? CMD_NONE : dec_cmd; // see (R21)
  wire is_rd = (cmd == CMD_READ);
  wire is_wr = (cmd == CMD_WRITE);
  wire in_data = (byte_cnt >= BYTE_DATA);
  wire [PAGE_W-1:0] page_off = addr[PAGE_W-1:0];
  wire [PAGE_W-1:0] next_off = page_off + 4'h1;

  // Suspend simply withholds every serial clock edge; held high it is inert
  wire link_run = spi_hold_n; // see (R18) see (R20)

  // Control part of the link: cleared between frames
  always_ff @(posedge spi_sck or posedge link_clr) begin // see (R14) see (R01)
    if (link_clr) begin
      bit_cnt <= BIT_FIRST;
      byte_cnt <= BYTE_OPCODE;
      cmd <= CMD_NONE;
      wr_mask <= '0;
    end else if (link_run) begin
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done) begin
        if (byte_cnt != BYTE_SAT) begin
          byte_cnt <= byte_cnt + 2'h1;
        end
        if (byte_cnt == BYTE_OPCODE) begin
          cmd <= next_cmd; // see (R08)
        end
        if (is_wr && in_data) begin
          wr_mask[page_off] <= 1'b1; // see (R03)
        end
      end
    end
  end

  // Data part of the link: no reset needed, qualified by the control part
  always_ff @(posedge spi_sck) begin
    if (link_run) begin
      rx_sh <= rx_byte[6:0]; // see (R10)
      if (byte_done && byte_cnt == BYTE_ADDR && (is_rd || is_wr)) begin
        addr <= rx_byte;
      end else if (byte_done && byte_cnt == BYTE_ADDR && cmd == CMD_STATUS_WRITE_CMD) begin
        sr_data <= rx_byte;
      end else if (byte_done && in_data && is_rd) begin
        addr <= addr + 8'h01; // see (R24)
      end else if (byte_done && in_data && is_wr) begin
        page_buf[page_off] <= rx_byte;
        addr <= {addr[ADDR_W-1:PAGE_W], next_off}; // see (R03)
      end
    end
  end

  // Array read crosses domains; safe since the array only changes while busy
  wire tx_phase = (cmd == CMD_STATUS_READ_CMD && byte_cnt >= BYTE_ADDR) || (is_rd && in_data);
  wire [DATA_W-1:0] tx_src = (cmd == CMD_STATUS_READ_CMD) ? link_status : mem[addr];

  always_ff @(negedge spi_sck or posedge link_clr) begin // see (R15)
    if (link_clr) begin
      spi_so <= 1'b0;
      tx_sh <= '0;
      tx_on <= 1'b0;
    end else if (link_run && tx_phase) begin
      tx_on <= 1'b1;
      if (bit_cnt == BIT_FIRST) begin
        {spi_so, tx_sh} <= tx_src; // see (R10)
      end else begin
        spi_so <= tx_sh[6];
        tx_sh <= {tx_sh[5:0], 1'b0};
      end
    end
  end

  // Status is quasi-static: changes only at frame end or cycle end
  sefe_sync #(.WIDTH(DATA_W)) u_status_sync (
    .clk(spi_sck),
    .en(1'b1),
    .d(status_reg),
    .q(link_status)
  );

  // ---------------- System side logic ----------------
  sefe_sync #(.WIDTH(4)) u_pin_sync (
    .clk(sys_clk),
    .en(clk_en),
    .d({spi_cs_n, spi_hold_n, wp_n, tx_on}),
    .q({cs_s, hold_s, wp_s, tx_s})
  );

  // Frame end seen while link state is still held
  wire commit = cs_s & ~ack & (state == ST_ACTIVE); // see (R12)
  wire aligned = (bit_cnt == BIT_FIRST); // see (R26)
  wire frame_ok = commit & aligned & ready; // see (R06)
  wire write_disable_cmd_done = frame_ok & (cmd == CMD_WRITE_DISABLE_CMD);
  wire wren_done = frame_ok & (cmd == CMD_WREN);
  wire status_write_cmd_done = frame_ok & (cmd == CMD_STATUS_WRITE_CMD) & (byte_cnt >= BYTE_DATA);
  wire write_done = frame_ok & is_wr & (wr_mask != '0);
  wire do_status_write_cmd = status_write_cmd_done & write_enable & ~hw_protect; // see (R17)
  wire do_write = write_done & write_enable;
  wire clr_wen = write_disable_cmd_done | status_write_cmd_done | write_done; // see (R22)
  wire prog_start = do_status_write_cmd | do_write; // see (R12)
  wire [1:0] bp = {block_protect_hi, block_protect_lo};
  wire [ADDR_W-PAGE_W-1:0] page = addr[ADDR_W-1:PAGE_W];
  wire next_hw = ~wp_s & protect_enable_bit; // see (R16)
  wire next_so_en_n = ~(~cs_s & hold_s & tx_s & ready); // see (R13) see (R25)

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack <= 1'b1;
      ready <= 1'b0;
    end else if (clk_en) begin
      ack <= cs_s;
      ready <= 1'b1; // see (R06)
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_STANDBY: begin
        if (!cs_s) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (commit) begin
          next_state = prog_start ? ST_PROGRAM : ST_STANDBY; // see (R07)
        end
      end
      ST_PROGRAM: begin
        if (prog_done) begin
          next_state = cs_s ? ST_STANDBY : ST_ACTIVE; // see (R07)
        end
      end
      default: begin
        next_state = ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ST_STANDBY; // see (R06)
      standby <= 1'b1;
    end else if (clk_en) begin
      state <= next_state;
      standby <= (next_state == ST_STANDBY);
    end
  end

  // Write enable: clear wins, it follows a write disable, status write or array write frame
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      write_enable <= 1'b0;
    end else if (clk_en) begin
      if (clr_wen) begin
        write_enable <= 1'b0; // see (R22)
      end else if (wren_done) begin
        write_enable <= 1'b1;
      end
    end
  end

  // Protection bits have no factory state here; reset gives unprotected
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      block_protect_lo <= 1'b0;
      block_protect_hi <= 1'b0;
      protect_enable_bit <= 1'b0;
      hw_protect <= 1'b0;
    end else if (clk_en) begin
      hw_protect <= next_hw; // see (R16)
      if (do_status_write_cmd) begin // see (R17)
        block_protect_lo <= sr_data[ST_BP_LO_BIT];
        block_protect_hi <= sr_data[ST_BP_HI_BIT];
        protect_enable_bit <= sr_data[ST_PROTECT_ENABLE_BIT_BIT];
      end
    end
  end

  // Whole masked page lands in one cycle, protected bytes skipped
  always_ff @(posedge sys_clk) begin
    if (clk_en && do_write) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (wr_mask[i] && !sefe_protected(bp, {page, PAGE_W'(i)})) begin // see (R05) see (R23)
          mem[{page, PAGE_W'(i)}] <= page_buf[i]; // see (R03)
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_reg <= STATUS_BUSY_VAL;
      spi_so_en_n <= 1'b1;
    end else if (clk_en) begin
      spi_so_en_n <= next_so_en_n;
      if (busy || !ready || prog_start) begin
        status_reg <= STATUS_BUSY_VAL; // see (R21)
      end else begin
        status_reg <= '0;
        status_reg[ST_WEN_BIT] <= write_enable;
        status_reg[ST_BP_LO_BIT] <= block_protect_lo;
        status_reg[ST_BP_HI_BIT] <= block_protect_hi;
        status_reg[ST_PROTECT_ENABLE_BIT_BIT] <= protect_enable_bit;
      end
    end
  end

  sefe_prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(prog_start), // see (R04)
    .busy(busy),
    .done(prog_done)
  );

endmodule : sefe_top

// File: sefe_monitor.sv
`timescale 1ns/1ps
module sefe_monitor #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic spi_cs_n, // Chip select
  input wire logic spi_hold_n, // Suspend
  input wire logic wp_n, // Write protect
  input wire logic spi_so_en_n, // Output enable
  input wire logic busy, // Program cycle
  input wire logic standby, // Standby
  input wire logic write_enable, // Enable latch
  input wire logic block_protect_lo, // Protect code low
  input wire logic block_protect_hi, // Protect code high
  input wire logic protect_enable_bit, // Protect enable
  input wire logic hw_protect // Hardware protect
);
  logic [31:0] busy_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Length of the last busy run, read at its falling edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !busy) busy_cnt <= 32'h0;
    else busy_cnt <= busy_cnt + 32'h1;
  end
  a_reset_exit: assert property ($rose(rst_n) |-> standby && !busy && !write_enable
    && spi_so_en_n && !hw_protect) else $error("state after reset wrong");
  a_standby_float: assert property (spi_cs_n [*8] |-> spi_so_en_n)
    else $error("output driven while deselected");
  a_hold_float: assert property (!spi_hold_n [*6] |-> spi_so_en_n)
    else $error("output driven while suspended");
  a_busy_len: assert property ($fell(busy) |-> busy_cnt >= PROG_CYCLES - 1
    && busy_cnt <= PROG_CYCLES + 1) else $error("program cycle length wrong");
  a_busy_standby: assert property (busy |-> !standby)
    else $error("standby during program cycle");
  a_standby_idle: assert property ((spi_cs_n && !busy) [*8] |-> standby)
    else $error("no standby when idle");
  a_hwp_on: assert property ((!wp_n && protect_enable_bit) [*6] |-> hw_protect)
    else $error("hardware protect not active");
  a_hwp_off: assert property (wp_n [*6] |-> !hw_protect)
    else $error("hardware protect without pin");
  a_prot_frozen: assert property (hw_protect |=>
    $stable({block_protect_hi, block_protect_lo, protect_enable_bit}))
    else $error("protection bits changed under protect");
  a_wen_clear: assert property ($rose(busy) |-> ##[0:2] !write_enable)
    else $error("enable latch kept after write");
endmodule : sefe_monitor

bind sefe_top sefe_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_sefe_monitor (
  .sys_clk(sys_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_hold_n(spi_hold_n),
  .wp_n(wp_n), .spi_so_en_n(spi_so_en_n), .busy(busy), .standby(standby),
  .write_enable(write_enable), .block_protect_lo(block_protect_lo),
  .block_protect_hi(block_protect_hi), .protect_enable_bit(protect_enable_bit),
  .hw_protect(hw_protect)
);

// File: sefe_master.sv
`timescale 1ns/1ps
module sefe_master (
  output logic sck, // Serial clock, still between frames
  output logic cs_n, // Chip select
  output logic si, // Serial data to device
  output logic hold_n, // Suspend
  input wire logic so, // Serial data from device
  input wire logic so_en_n // Output enable, low drives
);
  logic mode3;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    mode3 = 1'b0;
  end
  task automatic start(input logic m3);
    mode3 = m3;
    sck = m3;
    #5;
    cs_n = 1'b0;
    #16;
  endtask : start
  // Sends the top n bits; data changes with sck low
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx, input int n);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sck = 1'b0;
      si = tx[i];
      #16;
      rx[i] = so;
      sck = 1'b1;
      #16;
    end
  endtask : xbyte
  // Clock keeps toggling while held; device must ignore it
  task automatic pause();
    sck = 1'b0;
    #8;
    hold_n = 1'b0;
    repeat (2) begin
      #8 sck = 1'b1;
      si = ~si;
      #16 sck = 1'b0;
    end
    #8 hold_n = 1'b1;
    #8;
  endtask : pause
  task automatic stop();
    sck = mode3;
    #16;
    cs_n = 1'b1;
    si = ~si;
    #40;
  endtask : stop
endmodule : sefe_master

// File: testbench.sv
`timescale 1ns/1ps
module testbench
  import sefe_pkg::*;
();
  logic sys_clk, rst_n, wp_n, spi_sck, spi_cs_n, spi_si, spi_hold_n, spi_so, spi_so_en_n;
  logic busy, standby, write_enable, block_protect_lo, block_protect_hi;
  logic protect_enable_bit, hw_protect;
  logic [7:0] rx;
  logic [7:0] taddr [3] = '{8'hfe, 8'hff, 8'h00};
  logic [7:0] tdata [3] = '{8'ha1, 8'hb2, 8'h5a};
  int errors, checks_done;
  sefe_master m (.sck(spi_sck), .cs_n(spi_cs_n), .si(spi_si), .hold_n(spi_hold_n),
    .so(spi_so), .so_en_n(spi_so_en_n));
  sefe_top #(.PROG_CYCLES(200)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_hold_n(spi_hold_n),
    .wp_n(wp_n), .spi_so(spi_so), .spi_so_en_n(spi_so_en_n), .busy(busy),
    .standby(standby), .write_enable(write_enable), .block_protect_lo(block_protect_lo),
    .block_protect_hi(block_protect_hi), .protect_enable_bit(protect_enable_bit),
    .hw_protect(hw_protect));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic frame(input logic [7:0] b[$]);
    m.start(1'b0);
    foreach (b[i]) m.xbyte(b[i], rx, 8);
    m.stop();
  endtask : frame
  // Status byte is read twice to see it repeat
  task automatic status_read_cmd(input logic [7:0] exp, input logic [7:0] msk, input logic m3,
      input logic hp);
    m.start(m3);
    m.xbyte(OP_STATUS_READ, rx, 8);
    m.xbyte(8'h00, rx, 8);
    chk(rx & msk, exp);
    if (hp) m.pause();
    m.xbyte(8'h00, rx, 8);
    chk(rx & msk, exp);
    chk({7'h0, spi_so_en_n}, 8'h00);
    m.stop();
  endtask : status_read_cmd
  task automatic rd(input logic [7:0] a, input logic [7:0] e[$]);
    m.start(1'b0);
    m.xbyte(OP_READ, rx, 8);
    m.xbyte(a, rx, 8);
    foreach (e[i]) begin
      m.xbyte(8'h00, rx, 8);
      chk(rx, e[i]);
    end
    m.stop();
  endtask : rd
  // Busy rises a few cycles after deselect, so give it time first
  task automatic settle();
    int n;
    n = 0;
    repeat (8) @(posedge sys_clk);
    while ((busy !== 1'b0 || standby !== 1'b1) && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 400) begin
      errors++;
      $display("CHECK FAILED at %0t: device stuck busy", $time);
      final_report();
    end
  endtask : settle
  initial begin
    #700000;
    errors++;
    $display("CHECK FAILED at %0t: run too long", $time);
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    errors = 0;
    checks_done = 0;
    repeat (16) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    status_read_cmd(8'h00, 8'hff, 1'b0, 1'b0);
    frame('{OP_WRITE_ENABLE});
    repeat (2) @(posedge sys_clk);
    chk({7'h0, write_enable}, 8'h01);
    status_read_cmd(8'h02, 8'hff, 1'b1, 1'b0);
    frame('{OP_WRITE_DISABLE});
    status_read_cmd(8'h00, 8'hff, 1'b0, 1'b1);
    frame('{OP_WRITE_ENABLE});
    frame('{OP_WRITE, 8'hfe, 8'ha1, 8'hb2, 8'hc3});
    status_read_cmd(8'hff, 8'hff, 1'b0, 1'b0);
    frame('{OP_WRITE_ENABLE});
    settle();
    status_read_cmd(8'h00, 8'hff, 1'b0, 1'b0);
    frame('{OP_WRITE_ENABLE});
    frame('{OP_WRITE, 8'h00, 8'h5a});
    settle();
    rd(8'hfe, '{8'ha1, 8'hb2, 8'h5a});
    rd(8'hf0, '{8'hc3});
    frame('{OP_WRITE, 8'h00, 8'h77});
    settle();
    rd(8'h00, '{8'h5a});
    frame('{OP_WRITE_ENABLE});
    m.start(1'b0);
    m.xbyte(OP_WRITE, rx, 8);
    m.xbyte(8'h00, rx, 8);
    m.xbyte(8'h99, rx, 4);
    m.stop();
    status_read_cmd(8'h02, 8'hff, 1'b0, 1'b0);
    rd(8'h00, '{8'h5a});
    for (int c = 1; c < 4; c++) begin
      frame('{OP_WRITE_ENABLE});
      frame('{OP_STATUS_WRITE, {4'h0, c[1:0], 2'h0}});
      settle();
      status_read_cmd({4'h0, c[1:0], 2'h0}, 8'hff, 1'b0, 1'b0);
      frame('{OP_WRITE_ENABLE});
      frame('{OP_WRITE, taddr[c-1], 8'h3c});
      settle();
      rd(taddr[c-1], '{tdata[c-1]});
    end
    frame('{OP_WRITE_ENABLE});
    frame('{OP_STATUS_WRITE, 8'h80});
    settle();
    status_read_cmd(8'h80, 8'hff, 1'b0, 1'b0);
    chk({protect_enable_bit, 5'h0, block_protect_hi, block_protect_lo}, 8'h80);
    #1 wp_n = 1'b0;
    repeat (8) @(posedge sys_clk);
    chk({7'h0, hw_protect}, 8'h01);
    frame('{OP_WRITE_ENABLE});
    frame('{OP_STATUS_WRITE, 8'h0c});
    settle();
    status_read_cmd(8'h80, 8'h8c, 1'b0, 1'b0);
    #1 wp_n = 1'b1;
    repeat (8) @(posedge sys_clk);
    frame('{OP_WRITE_ENABLE});
    frame('{OP_STATUS_WRITE, 8'h00});
    settle();
    status_read_cmd(8'h00, 8'hff, 1'b0, 1'b0);
    final_report();
  end
endmodule : testbench
